/* File: logic/sample_seq_regs.vh */
// Offsets, field positions, reset values and timing counts of the
// sample rate and conversion sequencer.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
`ifndef SAMPLE_SEQ_REGS_VH
`define SAMPLE_SEQ_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CTRL_OFF          8'h00
`define BLOCK_OFF         8'h04
`define STATUS_OFF        8'h08

// ****************************************************************
// Control fields
// ****************************************************************
`define F_CHAN_A          0
`define F_CHAN_B          1
`define F_MUX_START       2
`define F_MON_SEL         3
`define F_FREQ_MODE       4
`define F_PRESCALE_A      5
`define F_PRESCALE_B      6
`define F_DECADE_A        7
`define F_DECADE_B        8
`define F_KILO_BYPASS     9
`define F_FREE_RUN        10
`define F_EXT_SAMPLE      11
`define F_SLOW_RATING     12
`define F_FOUR_CH_TIMING  13
`define CTRL_W            14
`define CTRL_RST          14'h0062
`define BLOCK_W           7
`define BLOCK_RST         7'h01

// ****************************************************************
// Status fields
// ****************************************************************
`define S_FREEZE          0
`define S_ARMED           1
`define S_TOO_FAST        2
`define S_TRIG_LAMP       3
`define S_BUSY            4
`define S_CHAN_LO         5

// ****************************************************************
// Rate codes flagged as too fast
// ****************************************************************
`define CODE_1M           6'd40
`define CODE_500K         6'd36
`define CODE_200K         6'd47

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ           25
`define PERIOD_PREDIV     10'd10
`define KICK_DELAY_NS     200
`define KICK_CYC          ((`KICK_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_NS         400
`define STROBE_CYC        ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define GAP_2CH_NS        80
`define GAP_2CH_CYC       ((`GAP_2CH_NS * `CLK_MHZ + 999) / 1000)
`define GAP_4CH_NS        320
`define GAP_4CH_CYC       ((`GAP_4CH_NS * `CLK_MHZ + 999) / 1000)
`define DISARM_NS         5000
`define DISARM_CYC        ((`DISARM_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: logic/sample_seq.v */
// Sample pulse generator, conversion sequencer and host handshake.
// Assumes oscillator and start inputs are plain levels sampled on
// clk_i, and an APB master on the same clock.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sample_seq_regs.vh"

module sample_seq (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        ref_20m_i,
    input  wire        ref_8m_i,
    input  wire        ext_sample_i,
    input  wire        mux_start_i,
    input  wire        host_accept_strobe_n_i,
    output reg         data_ready_n_o,
    input  wire        conversion_finished_i,
    output reg         track_freeze_o,
    output reg  [3:0]  conversion_kick_o,
    output reg  [3:0]  channel_output_select_o,
    output reg         sample_pulse_monitor_o,
    output reg         rate_too_fast_lamp_o,
    output reg         triggering_lamp_o,
    output wire        acquisition_armed_o
);

    localparam [7:0] ST_IDLE  = 8'h01;
    localparam [7:0] ST_DELAY = 8'h02;
    localparam [7:0] ST_CLOW  = 8'h04;
    localparam [7:0] ST_CHIGH = 8'h08;
    localparam [7:0] ST_GAP   = 8'h10;
    localparam [7:0] ST_STRB  = 8'h20;
    localparam [7:0] ST_REL   = 8'h40;
    localparam [7:0] ST_REASS = 8'h80;

    // Counts less one; part-selects cut them to the counter widths
    localparam [31:0] KICK_LAST   = `KICK_CYC - 1;
    localparam [31:0] STROBE_LAST = `STROBE_CYC - 1;
    localparam [31:0] GAP2_LAST   = `GAP_2CH_CYC - 1;
    localparam [31:0] GAP4_LAST   = `GAP_4CH_CYC - 1;
    localparam [31:0] DISARM_LAST = `DISARM_CYC - 1;

    // ****************************************************************
    // Decoders
    // ****************************************************************
    function [2:0] chan_last;
        input a;
        input b;
        begin
            case ({a, b})
                2'b01:   chan_last = 3'd0;
                2'b11:   chan_last = 3'd1;
                2'b00:   chan_last = 3'd2;
                default: chan_last = 3'd3;
            endcase
        end
    endfunction

    function [3:0] chan_mask;
        input [2:0] last;
        begin
            case (last)
                3'd0:    chan_mask = 4'h1;
                3'd1:    chan_mask = 4'h3;
                3'd2:    chan_mask = 4'h7;
                default: chan_mask = 4'hf;
            endcase
        end
    endfunction

    // ****************************************************************
    // Registers and APB slave
    // ****************************************************************
    reg  [`CTRL_W-1:0]  ctrl_reg;
    reg  [`BLOCK_W-1:0] block_reg;
    reg  [7:0]          state_reg;
    reg                 armed_reg;
    reg  [1:0]          idx_reg;
    wire [31:0]         status_w;
    wire                hit_ctrl;
    wire                hit_block;
    wire                hit_status;
    wire                hit_any;

    assign hit_ctrl   = (paddr_i == `CTRL_OFF);
    assign hit_block  = (paddr_i == `BLOCK_OFF);
    assign hit_status = (paddr_i == `STATUS_OFF);
    assign hit_any    = hit_ctrl | hit_block | hit_status;
    assign pready_o   = 1'b1;
    // Status is read only, so a write to it is refused too
    assign pslverr_o  = psel_i & penable_i & (~hit_any
                        | (pwrite_i & hit_status));

    assign status_w = {25'h0000000, idx_reg,
                       (state_reg != ST_IDLE), triggering_lamp_o,
                       rate_too_fast_lamp_o, armed_reg, track_freeze_o};

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg  <= `CTRL_RST;
            block_reg <= `BLOCK_RST;
            prdata_o  <= 32'h00000000;
        end else begin
            if (psel_i & penable_i & pwrite_i & hit_ctrl)
                ctrl_reg <= pwdata_i[`CTRL_W-1:0];
            if (psel_i & penable_i & pwrite_i & hit_block)
                block_reg <= pwdata_i[`BLOCK_W-1:0];
            // Loaded in the setup cycle so data stands in the access cycle
            if (psel_i & ~penable_i) begin
                if (hit_ctrl)
                    prdata_o <= {18'h00000, ctrl_reg};
                else if (hit_block)
                    prdata_o <= {25'h0000000, block_reg};
                else if (hit_status)
                    prdata_o <= status_w;
                else
                    prdata_o <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    wire [3:0] raw_w;
    wire [3:0] edge_w;
    assign raw_w = {mux_start_i, ext_sample_i, ref_8m_i, ref_20m_i};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : sync
            reg meta_reg;
            reg sync_reg;
            reg last_reg;
            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    last_reg <= 1'b0;
                end else begin
                    meta_reg <= raw_w[g];
                    sync_reg <= meta_reg;
                    last_reg <= sync_reg;
                end
            end
            assign edge_w[g] = sync_reg & ~last_reg;
        end
    endgenerate

    // ****************************************************************
    // Divider chain
    // ****************************************************************
    // A reference faster than half of clk_i aliases; a real build
    // would run the first stage in the oscillator's own domain.
    reg  [9:0]  blk_div;
    reg  [9:0]  pre_div;
    reg  [9:0]  dec_div;
    wire [39:0] divs_w;
    wire [4:0]  tick_w;
    wire        gen_run;

    always @* begin
        blk_div = 10'd1;
        case (1'b1)
            block_reg[0]: blk_div = 10'd1;
            block_reg[1]: blk_div = 10'd2;
            block_reg[2]: blk_div = 10'd4;
            block_reg[3]: blk_div = 10'd8;
            block_reg[4]: blk_div = 10'd16;
            block_reg[5]: blk_div = 10'd32;
            block_reg[6]: blk_div = 10'd64;
            default:      blk_div = 10'd1;
        endcase
        case ({ctrl_reg[`F_PRESCALE_A], ctrl_reg[`F_PRESCALE_B]})
            2'b11:   pre_div = 10'd1;
            2'b01:   pre_div = 10'd2;
            2'b10:   pre_div = 10'd4;
            default: pre_div = 10'd10;
        endcase
        case ({ctrl_reg[`F_DECADE_A], ctrl_reg[`F_DECADE_B]})
            2'b00:   dec_div = 10'd1;
            2'b11:   dec_div = 10'd10;
            2'b01:   dec_div = 10'd100;
            default: dec_div = 10'd1000;
        endcase
    end

    // Stage 0 pre-divides the selected reference
    assign divs_w = {(ctrl_reg[`F_KILO_BYPASS] ? 10'd1 : 10'd1000),
                     dec_div, pre_div,
                     (ctrl_reg[`F_FREQ_MODE] ? blk_div : `PERIOD_PREDIV)};
    assign tick_w[0] = ctrl_reg[`F_FREQ_MODE] ? edge_w[1] : edge_w[0];
    // the period pre-divide of ten turns 20 MHz into 2 MHz

    generate
        for (g = 0; g < 4; g = g + 1) begin : stage
            reg  [9:0] cnt_reg;
            wire [9:0] div_w;
            wire       wrap_w;
            assign div_w  = divs_w[10*g+9:10*g];
            // At or past the end, so a smaller ratio never waits a lap
            assign wrap_w = (cnt_reg >= div_w - 10'd1);
            always @(posedge clk_i) begin
                if (sys_rst_i | ~gen_run)
                    cnt_reg <= 10'd0;
                else if (tick_w[g])
                    cnt_reg <= wrap_w ? 10'd0 : cnt_reg + 10'd1;
            end
            assign tick_w[g+1] = tick_w[g] & wrap_w;
        end
    endgenerate

    assign gen_run = ctrl_reg[`F_FREE_RUN] | armed_reg;

    // ****************************************************************
    // Sample selection, monitor and lamps
    // ****************************************************************
    wire       ctl_pulse;
    wire       start_pulse;
    wire [5:0] rate_code;

    assign ctl_pulse   = ctrl_reg[`F_EXT_SAMPLE] ? edge_w[2] : tick_w[4];
    assign start_pulse = ctrl_reg[`F_MUX_START] ? edge_w[3] : ctl_pulse;
    assign rate_code   = {ctrl_reg[`F_KILO_BYPASS], ctrl_reg[`F_FREQ_MODE],
                          ctrl_reg[`F_PRESCALE_B], ctrl_reg[`F_PRESCALE_A],
                          ctrl_reg[`F_DECADE_B], ctrl_reg[`F_DECADE_A]};

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sample_pulse_monitor_o <= 1'b0;
            rate_too_fast_lamp_o   <= 1'b0;
            triggering_lamp_o      <= 1'b0;
        end else begin
            sample_pulse_monitor_o <= ctrl_reg[`F_MON_SEL] ?
                                      ctl_pulse : tick_w[4];
            rate_too_fast_lamp_o <= (rate_code == `CODE_1M)
                | (rate_code == `CODE_500K)
                | (ctrl_reg[`F_SLOW_RATING]
                   & (rate_code == `CODE_200K));
            triggering_lamp_o <= gen_run;
        end
    end

    // ****************************************************************
    // Arming
    // ****************************************************************
    reg [7:0] disarm_reg;
    assign acquisition_armed_o = armed_reg;

    // Idle release longer than the window means the host is done
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            armed_reg  <= 1'b0;
            disarm_reg <= 8'd0;
        end else if (~host_accept_strobe_n_i) begin
            armed_reg  <= 1'b1;
            disarm_reg <= 8'd0;
        end else if (state_reg != ST_IDLE) begin
            disarm_reg <= 8'd0;
        end else if (armed_reg) begin
            if (disarm_reg == DISARM_LAST[7:0]) begin
                armed_reg  <= 1'b0;
                disarm_reg <= 8'd0;
            end else begin
                disarm_reg <= disarm_reg + 8'd1;
            end
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    reg  [3:0] wait_reg;
    wire [2:0] last_w;
    wire [3:0] gap_w;

    assign last_w = chan_last(ctrl_reg[`F_CHAN_A], ctrl_reg[`F_CHAN_B]);
    assign gap_w  = ctrl_reg[`F_FOUR_CH_TIMING] ?
                    GAP4_LAST[3:0] : GAP2_LAST[3:0];

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg               <= ST_IDLE;
            track_freeze_o          <= 1'b0;
            conversion_kick_o       <= 4'h0;
            channel_output_select_o <= 4'h0;
            data_ready_n_o          <= 1'b1;
            idx_reg                 <= 2'd0;
            wait_reg                <= 4'd0;
        end else begin
            conversion_kick_o <= 4'h0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_pulse & armed_reg) begin
                        track_freeze_o <= 1'b1;
                        wait_reg       <= KICK_LAST[3:0];
                        state_reg      <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (wait_reg == 4'd0) begin
                        conversion_kick_o <= chan_mask(last_w);
                        state_reg         <= ST_CLOW;
                    end else begin
                        wait_reg <= wait_reg - 4'd1;
                    end
                end
                ST_CLOW: begin
                    if (~conversion_finished_i)
                        state_reg <= ST_CHIGH;
                end
                ST_CHIGH: begin
                    if (conversion_finished_i) begin
                        track_freeze_o <= 1'b0;
                        idx_reg        <= 2'd0;
                        wait_reg       <= gap_w;
                        // Without a waiting host the word is dropped
                        state_reg <= host_accept_strobe_n_i ?
                                     ST_IDLE : ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (wait_reg == 4'd0) begin
                        data_ready_n_o <= 1'b0;
                        channel_output_select_o <= 4'h1 << idx_reg;
                        wait_reg  <= STROBE_LAST[3:0];
                        state_reg <= ST_STRB;
                    end else begin
                        wait_reg <= wait_reg - 4'd1;
                    end
                end
                ST_STRB: begin
                    if (wait_reg == 4'd0) begin
                        data_ready_n_o <= 1'b1;
                        state_reg      <= ST_REL;
                    end else begin
                        wait_reg <= wait_reg - 4'd1;
                    end
                end
                ST_REL: begin
                    if (host_accept_strobe_n_i) begin
                        channel_output_select_o <= 4'h0;
                        state_reg <= ({1'b0, idx_reg} == last_w) ?
                                     ST_IDLE : ST_REASS;
                    end
                end
                ST_REASS: begin
                    if (~host_accept_strobe_n_i) begin
                        idx_reg   <= idx_reg + 2'd1;
                        wait_reg  <= gap_w;
                        state_reg <= ST_GAP;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: verif/sample_seq_assertions.sv */
// Concurrent checks on the sequencer's conversion and handshake ports.
// Assumes it is bound onto sample_seq, sharing its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module sample_seq_assertions (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       host_accept_strobe_n_i,
    input wire logic       data_ready_n_o,
    input wire logic       conversion_finished_i,
    input wire logic       track_freeze_o,
    input wire logic [3:0] conversion_kick_o,
    input wire logic [3:0] channel_output_select_o,
    input wire logic       sample_pulse_monitor_o,
    input wire logic       acquisition_armed_o
);
    // ************
    // Strobe width
    // ************
    // Counter keeps the long strobe check cheap for the tools
    logic [4:0] low_cnt;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || data_ready_n_o) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1f) begin
            low_cnt <= low_cnt + 5'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    freeze_to_kick_a: assert property ($rose(track_freeze_o) |->
        (conversion_kick_o == 4'h0) [*5] ##1 (conversion_kick_o != 4'h0))
        else $error("kick not five cycles after freeze");
    kick_mask_a: assert property (conversion_kick_o != 4'h0 |->
        conversion_kick_o inside {4'h1, 4'h3, 4'h7, 4'hf})
        else $error("kick mask not a channel count");
    kick_in_freeze_a: assert property (conversion_kick_o != 4'h0 |->
        track_freeze_o ##1 conversion_kick_o == 4'h0)
        else $error("kick outside freeze or too long");
    freeze_release_a: assert property (track_freeze_o &&
        $rose(conversion_finished_i) |-> ##[1:3] !track_freeze_o)
        else $error("freeze held after finish");
    strobe_width_a: assert property ($rose(data_ready_n_o) |->
        low_cnt == 5'd10) else $error("strobe width wrong");
    strobe_accept_a: assert property ($fell(data_ready_n_o) |->
        !host_accept_strobe_n_i) else $error("strobe without accept");
    select_onehot_a: assert property (!data_ready_n_o |->
        $onehot(channel_output_select_o))
        else $error("select not one-hot in strobe");
    armed_gate_a: assert property ($rose(track_freeze_o) |->
        $past(acquisition_armed_o)) else $error("sample while unarmed");
    monitor_pulse_a: assert property (sample_pulse_monitor_o |=>
        !sample_pulse_monitor_o) else $error("monitor pulse too long");
    cover property (conversion_kick_o == 4'hf);
    cover property ($rose(data_ready_n_o));
    cover property (sample_pulse_monitor_o);
endmodule
bind sample_seq sample_seq_assertions chk (
    .clk_i, .sys_rst_i, .host_accept_strobe_n_i, .data_ready_n_o,
    .conversion_finished_i, .track_freeze_o, .conversion_kick_o,
    .channel_output_select_o, .sample_pulse_monitor_o,
    .acquisition_armed_o);
`default_nettype wire

/* File: verif/adc_host_model.sv */
// Host channel and channel A digitizer as seen from the sequencer.
// Assumes the sequencer's clock; slow_i stretches conversion and release.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       host_on_i,
    input  wire logic       slow_i,
    input  wire logic       data_ready_n_i,
    input  wire logic [3:0] conversion_kick_i,
    output var  logic       host_accept_strobe_n_o,
    output var  logic       conversion_finished_o
);
    // *********
    // Handshake
    // *********
    logic [4:0] conv_cnt;
    logic [2:0] rel_cnt;
    logic       dr_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            conversion_finished_o  <= 1'b1;
            host_accept_strobe_n_o <= 1'b1;
            conv_cnt               <= 5'h00;
            rel_cnt                <= 3'h0;
            dr_q                   <= 1'b1;
        end else begin
            dr_q <= data_ready_n_i;
            if (conversion_kick_i[0]) begin
                conversion_finished_o <= 1'b0;
                conv_cnt <= slow_i ? 5'h14 : 5'h03;
            end else if (conv_cnt != 5'h00) begin
                conv_cnt <= conv_cnt - 5'h01;
                conversion_finished_o <= (conv_cnt == 5'h01);
            end
            // Release after each word, then ask for the next one
            if (!host_on_i) begin
                host_accept_strobe_n_o <= 1'b1;
            end else if (data_ready_n_i && !dr_q) begin
                host_accept_strobe_n_o <= 1'b1;
                rel_cnt <= slow_i ? 3'h6 : 3'h2;
            end else if (rel_cnt != 3'h0) begin
                rel_cnt <= rel_cnt - 3'h1;
            end else begin
                host_accept_strobe_n_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_sample_seq.sv */
// Self-checking bench: divider rates, conversions, arming, registers.
// Assumes references tick every 4 clocks and the host model above.
`timescale 1ns/1ps
`default_nettype none
`include "sample_seq_regs.vh"
module tb_sample_seq;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
    logic        pready_o, pslverr_o, serr;
    logic        ref_20m_i = 1'b0, ref_8m_i = 1'b0, rdiv = 1'b0;
    logic        ext_sample_i = 1'b0, mux_start_i = 1'b0;
    logic        host_accept_strobe_n_i, data_ready_n_o, dr_q = 1'b1;
    logic        conversion_finished_i, track_freeze_o, fin_q = 1'b1;
    logic [3:0]  conversion_kick_o, channel_output_select_o, kick_mask;
    logic        sample_pulse_monitor_o, rate_too_fast_lamp_o;
    logic        triggering_lamp_o, acquisition_armed_o;
    logic        host_on = 1'b0, slow = 1'b0;
    logic [3:0]  sel_log [4];
    int          fails = 0, total_checks = 0, cyc = 0, i, k, n0;
    int          kicks, nstb, nmon = 0, last_mon = 0, gap, fin_t, dly [4];
    // *****************
    // Rate table rows
    // *****************
    logic [13:0] row_ctrl [8] = '{14'h0662, 14'h0642, 14'h0622, 14'h0602,
                                  14'h07e2, 14'h17e2, 14'h0672, 14'h0672};
    logic [6:0]  row_blk [8]  = '{7'h01, 7'h01, 7'h01, 7'h01,
                                  7'h01, 7'h01, 7'h40, 7'h08};
    int          row_div [8]  = '{10, 20, 40, 100, 100, 100, 64, 8};
    logic        row_lamp [8] = '{1'b0, 1'b1, 1'b1, 1'b0,
                                  1'b0, 1'b1, 1'b0, 1'b0};
    logic [1:0]  cc [4]       = '{2'h2, 2'h3, 2'h0, 2'h1};
    sample_seq dut (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ref_20m_i,
        .ref_8m_i, .ext_sample_i, .mux_start_i, .host_accept_strobe_n_i,
        .data_ready_n_o, .conversion_finished_i, .track_freeze_o,
        .conversion_kick_o, .channel_output_select_o,
        .sample_pulse_monitor_o, .rate_too_fast_lamp_o, .triggering_lamp_o,
        .acquisition_armed_o);
    adc_host_model host (.clk_i, .sys_rst_i, .host_on_i(host_on),
        .slow_i(slow), .data_ready_n_i(data_ready_n_o),
        .conversion_kick_i(conversion_kick_o),
        .host_accept_strobe_n_o(host_accept_strobe_n_i),
        .conversion_finished_o(conversion_finished_i));
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        rdiv <= ~rdiv;
        if (rdiv) begin
            ref_20m_i <= ~ref_20m_i;
            ref_8m_i <= ~ref_8m_i;
        end
    end
    task report_and_stop;
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rdata = prdata_o;
        serr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task pulse(input logic m);
        if (m) mux_start_i <= 1'b1;
        else ext_sample_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        mux_start_i <= 1'b0;
        ext_sample_i <= 1'b0;
    endtask
    // Watcher; it samples before the design's updates land
    always @(posedge clk_i) begin
        cyc++;
        if (conversion_kick_o != 4'h0) begin
            kicks++;
            kick_mask = conversion_kick_o;
        end
        if (conversion_finished_i && !fin_q) fin_t = cyc;
        if (!data_ready_n_o && dr_q && nstb < 4) begin
            if (nstb == 0) dly[i % 4] = cyc - fin_t;
            sel_log[nstb] = channel_output_select_o;
            nstb++;
        end
        if (sample_pulse_monitor_o) begin
            gap = cyc - last_mon;
            last_mon = cyc;
            nmon++;
        end
        dr_q = data_ready_n_o;
        fin_q = conversion_finished_i;
        if (cyc > 40000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, `CTRL_OFF, {18'h0, row_ctrl[i]});
            apb(1'b1, `BLOCK_OFF, {25'h0, row_blk[i]});
            n0 = nmon;
            for (k = 0; k < 3000 && nmon < n0 + 3; k++) @(posedge clk_i);
            cmp(gap, row_div[i] * 4, "sample rate");
            cmp(rate_too_fast_lamp_o, row_lamp[i], "rate lamp");
            cmp(triggering_lamp_o, 1'b1, "free run lamp");
        end
        host_on <= 1'b1;
        for (i = 0; i < 4; i++) begin
            slow <= i[0];
            apb(1'b1, `CTRL_OFF, 32'h0868 | cc[i] | (i == 3 ? 32'h2000 : 0));
            repeat (4) @(posedge clk_i);
            cmp(acquisition_armed_o, 1'b1, "armed");
            kicks = 0;
            nstb = 0;
            n0 = nmon;
            pulse(1'b0);
            repeat (12) @(posedge clk_i);
            pulse(1'b0);
            for (k = 0; k < 600 && nstb < i + 1; k++) @(posedge clk_i);
            repeat (40) @(posedge clk_i);
            cmp(kicks, 1, "one conversion");
            cmp(kick_mask, (1 << (i + 1)) - 1, "kick mask");
            cmp(nstb, i + 1, "strobe count");
            for (k = 0; k <= i; k++) cmp(sel_log[k], 1 << k, "select");
            cmp(nmon != n0, 1'b1, "monitor");
            cmp(track_freeze_o, 1'b0, "freeze");
        end
        cmp(dly[3] - dly[2], `GAP_4CH_CYC - `GAP_2CH_CYC, "reply");
        apb(1'b1, `CTRL_OFF, 32'h006e);
        kicks = 0;
        pulse(1'b1);
        repeat (60) @(posedge clk_i);
        cmp(kicks, 1, "mux start");
        cmp(triggering_lamp_o, 1'b1, "armed lamp");
        host_on <= 1'b0;
        repeat (110) @(posedge clk_i);
        cmp(acquisition_armed_o, 1'b1, "early disarm");
        repeat (30) @(posedge clk_i);
        cmp(acquisition_armed_o, 1'b0, "disarm");
        cmp(triggering_lamp_o, 1'b0, "stopped lamp");
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cmp(data_ready_n_o, 1'b1, "reset strobe");
        apb(1'b0, `CTRL_OFF, 32'h0);
        cmp(rdata, 32'h0000_0062, "ctrl reset");
        apb(1'b0, `BLOCK_OFF, 32'h0);
        cmp(rdata, 32'h0000_0001, "block reset");
        apb(1'b0, `STATUS_OFF, 32'h0);
        cmp(rdata, 32'h0000_0000, "status reset");
        apb(1'b0, 8'h0c, 32'h0);
        cmp(rdata, 32'h0, "unmapped read");
        cmp(serr, 1'b1, "unmapped error");
        apb(1'b1, `STATUS_OFF, 32'h1f);
        cmp(serr, 1'b1, "status write");
        apb(1'b1, `CTRL_OFF, 32'hffff_ffff);
        apb(1'b0, `CTRL_OFF, 32'h0);
        cmp(rdata, 32'h0000_3fff, "ctrl width");
        report_and_stop;
    end
endmodule
`default_nettype wire
